// ### rtl/pcs_defines.vh
// Constants for the configuration and status pin block
// Functional notes
// - Strap source select low gives hardware mode, high gives software mode.
// - Hardware mode: duplex pin is an input, low half, high full duplex.
// - Software mode: device drives duplex pin, low half, high full duplex.
// - Lock output high while descrambler holds lock, low otherwise.
// - Link-up output high while link established, low otherwise.
// - Port format select low gives media independent interface.
// - Port format select high: symbol stream at 100M, serial at 10M.
// - Node-or-repeater select low gives node role, high gives repeater role.
// - Role selection changes signal-quality test and carrier-sense generation.
// - Device held in reset while active-low hardware reset is low.
// - Speed pin: input in hardware mode, reports selected speed in software mode.
// - Autoneg pin: input in hardware mode, reports autoneg enable in software mode.
// - Full duplex or repeater: carrier sense on receive only; else receive or transmit.
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PCS_ADDR_CTRL 8'h00
`define PCS_ADDR_STAT 8'h04
`define PCS_ADDR_IRQ_STAT 8'h08
`define PCS_ADDR_IRQ_MASK 8'h0C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PCS_CTRL_DUPLEX 0
`define PCS_CTRL_SPEED 1
`define PCS_CTRL_ANEG 2
`define PCS_CTRL_SQE_INH 3
`define PCS_CTRL_RESET 4'h0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define PCS_ST_SW_MODE 0
`define PCS_ST_DUPLEX 1
`define PCS_ST_SPEED 2
`define PCS_ST_ANEG 3
`define PCS_ST_REPEATER 4
`define PCS_ST_FMT_LO 5
`define PCS_ST_LOCK 7
`define PCS_ST_LINK 8
`define PCS_ST_CRS 9
`define PCS_ST_SQE 10

// ----------------------------------------
// Interrupt event bits
// ----------------------------------------
`define PCS_EV_LINK_UP 0
`define PCS_EV_LINK_DOWN 1
`define PCS_EV_LOCK_LOST 2
`define PCS_EV_NUM 3

// ----------------------------------------
// Port format encodings
// ----------------------------------------
`define PCS_FMT_MII 2'h0
`define PCS_FMT_SYMBOL 2'h1
`define PCS_FMT_SERIAL 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCS_CLK_MHZ 25
`define PCS_SQE_NS 1000
`define PCS_SQE_CYC ((`PCS_SQE_NS * `PCS_CLK_MHZ) / 1000)

`endif

// ### rtl/pcs_sync.v
// Two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module pcs_sync #(
   parameter WIDTH = 8
) (
   // Clock
   input wire clk_i,
   // Asynchronous inputs
   input wire [WIDTH-1:0] async_i,
   // Synchronised outputs
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;

   // Per-bit double flop; first stage read only by second
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
         always @(posedge clk_i) begin
            meta[gi] <= async_i[gi];
            stable[gi] <= meta[gi];
         end
      end
   endgenerate

   assign sync_o = stable;

endmodule

`default_nettype wire

// ### rtl/pcs_top.v
// Configuration and status pin logic with Wishbone register access
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.vh"

module pcs_top #(
   parameter SQE_CYC = `PCS_SQE_CYC
) (
   // Clock and bus reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Strap and reset pins
   input wire hw_reset_n_i,
   input wire strap_source_select_i,
   input wire port_format_select_i,
   input wire node_or_repeater_select_i,
   // Two-way configuration pins
   input wire duplex_select_pin_i,
   output reg duplex_select_pin_o,
   output reg duplex_select_pin_oe_o,
   input wire speed_select_pin_i,
   output reg speed_select_pin_o,
   output reg speed_select_pin_oe_o,
   input wire autoneg_select_pin_i,
   output reg autoneg_select_pin_o,
   output reg autoneg_select_pin_oe_o,
   // Status from the physical layer core
   input wire core_lock_i,
   input wire core_link_i,
   input wire core_rx_active_i,
   input wire core_tx_active_i,
   input wire core_tx_end_i,
   // Status pins
   output reg descrambler_lock_o,
   output reg link_up_out_o,
   // Derived configuration to the core
   output reg core_reset_o,
   output reg full_duplex_o,
   output reg speed_100_o,
   output reg autoneg_en_o,
   output reg repeater_o,
   output reg [1:0] port_format_o,
   output reg carrier_sense_o,
   output reg sqe_pulse_o,
   output reg irq_o
);

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   wire [6:0] pin_s;
   pcs_sync #(.WIDTH(7)) u_sync (
      .clk_i(clk_i),
      .async_i({hw_reset_n_i, strap_source_select_i, port_format_select_i,
                node_or_repeater_select_i, duplex_select_pin_i,
                speed_select_pin_i, autoneg_select_pin_i}),
      .sync_o(pin_s)
   );

   wire rst_n_s = pin_s[6];
   wire sw_mode = pin_s[5];
   wire fmt_s = pin_s[4];
   wire rep_s = pin_s[3];
   wire dpx_s = pin_s[2];
   wire spd_s = pin_s[1];
   wire aneg_s = pin_s[0];

   // Combined reset: bus reset or hardware reset pin low
   wire hold = rst_i | ~rst_n_s;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Software registers
   reg [3:0] ctrl;
   reg [`PCS_EV_NUM-1:0] irq_stat;
   reg [`PCS_EV_NUM-1:0] irq_mask;
   // Edge history and pulse counter
   reg link_q;
   reg lock_q;
   reg [15:0] sqe_cnt;
   reg tx_end_q;

   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = bus_req & wb_we_i & wb_sel_i[0];

   // Effective selections: pins in hardware mode, registers in software mode
   wire next_dpx = sw_mode ? ctrl[`PCS_CTRL_DUPLEX] : dpx_s;
   wire next_spd = sw_mode ? ctrl[`PCS_CTRL_SPEED] : spd_s;
   wire next_aneg = sw_mode ? ctrl[`PCS_CTRL_ANEG] : aneg_s;

   // Port format from select pin and speed
   reg [1:0] next_fmt;
   always @* begin
      if (!fmt_s) begin
         next_fmt = `PCS_FMT_MII;
      end else if (next_spd) begin
         next_fmt = `PCS_FMT_SYMBOL;
      end else begin
         next_fmt = `PCS_FMT_SERIAL;
      end
   end

   // Carrier sense by role and duplex
   wire next_crs = (next_dpx | rep_s) ? core_rx_active_i :
                   (core_rx_active_i | core_tx_active_i);

   // Events from link and lock edges
   wire [`PCS_EV_NUM-1:0] ev_raw;
   wire [`PCS_EV_NUM-1:0] ev;
   assign ev_raw[`PCS_EV_LINK_UP] = core_link_i & ~link_q;
   assign ev_raw[`PCS_EV_LINK_DOWN] = ~core_link_i & link_q;
   assign ev_raw[`PCS_EV_LOCK_LOST] = ~core_lock_i & lock_q;
   // Edge history is cleared while held, so mute events then
   assign ev = hold ? {`PCS_EV_NUM{1'b0}} : ev_raw;

   // SQE test only in node role at half duplex after transmit end, unless inhibited
   wire sqe_start = core_tx_end_i & ~tx_end_q & ~rep_s & ~next_dpx &
                    ~ctrl[`PCS_CTRL_SQE_INH];

   // ----------------------------------------
   // Bus read mux
   // ----------------------------------------
   reg [31:0] rd_data;
   always @* begin
      rd_data = 32'h00000000;
      case (wb_adr_i)
         `PCS_ADDR_CTRL: rd_data[3:0] = ctrl;
         `PCS_ADDR_STAT: begin
            rd_data[`PCS_ST_SW_MODE] = sw_mode;
            rd_data[`PCS_ST_DUPLEX] = full_duplex_o;
            rd_data[`PCS_ST_SPEED] = speed_100_o;
            rd_data[`PCS_ST_ANEG] = autoneg_en_o;
            rd_data[`PCS_ST_REPEATER] = repeater_o;
            rd_data[`PCS_ST_FMT_LO+1:`PCS_ST_FMT_LO] = port_format_o;
            rd_data[`PCS_ST_LOCK] = descrambler_lock_o;
            rd_data[`PCS_ST_LINK] = link_up_out_o;
            rd_data[`PCS_ST_CRS] = carrier_sense_o;
            rd_data[`PCS_ST_SQE] = sqe_pulse_o;
         end
         `PCS_ADDR_IRQ_STAT: rd_data[`PCS_EV_NUM-1:0] = irq_stat;
         `PCS_ADDR_IRQ_MASK: rd_data[`PCS_EV_NUM-1:0] = irq_mask;
         default: rd_data = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // Bus slave and software registers
   // ----------------------------------------
   // One-cycle registered acknowledge with read data
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // Control and mask registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `PCS_CTRL_RESET;
         irq_mask <= 3'h0;
      end else begin
         if (wr && wb_adr_i == `PCS_ADDR_CTRL) begin
            ctrl <= wb_dat_i[3:0];
         end
         if (wr && wb_adr_i == `PCS_ADDR_IRQ_MASK) begin
            irq_mask <= wb_dat_i[`PCS_EV_NUM-1:0];
         end
      end
   end

   // Sticky events; set wins over write-one-to-clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= 3'h0;
      end else if (wr && wb_adr_i == `PCS_ADDR_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~wb_dat_i[`PCS_EV_NUM-1:0]) | ev;
      end else begin
         irq_stat <= irq_stat | ev;
      end
   end

   // ----------------------------------------
   // Reset and pin drive
   // ----------------------------------------
   // Core reset follows the combined hold
   always @(posedge clk_i) begin
      if (hold) begin
         core_reset_o <= 1'b1;
      end else begin
         core_reset_o <= 1'b0;
      end
   end

   // Drive the two-way pins only in software mode
   always @(posedge clk_i) begin
      if (hold) begin
         duplex_select_pin_o <= 1'b0;
         duplex_select_pin_oe_o <= 1'b0;
         speed_select_pin_o <= 1'b0;
         speed_select_pin_oe_o <= 1'b0;
         autoneg_select_pin_o <= 1'b0;
         autoneg_select_pin_oe_o <= 1'b0;
      end else begin
         duplex_select_pin_oe_o <= sw_mode;
         duplex_select_pin_o <= ctrl[`PCS_CTRL_DUPLEX];
         speed_select_pin_oe_o <= sw_mode;
         speed_select_pin_o <= ctrl[`PCS_CTRL_SPEED];
         autoneg_select_pin_oe_o <= sw_mode;
         autoneg_select_pin_o <= ctrl[`PCS_CTRL_ANEG];
      end
   end

   // ----------------------------------------
   // Status and derived configuration
   // ----------------------------------------
   // Lock and link pins copy the core one cycle late
   always @(posedge clk_i) begin
      if (hold) begin
         descrambler_lock_o <= 1'b0;
         link_up_out_o <= 1'b0;
      end else begin
         descrambler_lock_o <= core_lock_i;
         link_up_out_o <= core_link_i;
      end
   end

   // Selections handed to the core
   always @(posedge clk_i) begin
      if (hold) begin
         full_duplex_o <= 1'b0;
         speed_100_o <= 1'b0;
         autoneg_en_o <= 1'b0;
         repeater_o <= 1'b0;
         port_format_o <= `PCS_FMT_MII;
         carrier_sense_o <= 1'b0;
      end else begin
         full_duplex_o <= next_dpx;
         speed_100_o <= next_spd;
         autoneg_en_o <= next_aneg;
         repeater_o <= rep_s;
         port_format_o <= next_fmt;
         carrier_sense_o <= next_crs;
      end
   end

   // Previous core levels for edge detection
   always @(posedge clk_i) begin
      if (hold) begin
         link_q <= 1'b0;
         lock_q <= 1'b0;
         tx_end_q <= 1'b0;
      end else begin
         link_q <= core_link_i;
         lock_q <= core_lock_i;
         tx_end_q <= core_tx_end_i;
      end
   end

   // ----------------------------------------
   // Signal-quality test pulse
   // ----------------------------------------
   // Pulse of fixed length; a new start reloads the count
   always @(posedge clk_i) begin
      if (hold) begin
         sqe_pulse_o <= 1'b0;
         sqe_cnt <= 16'h0000;
      end else if (sqe_start) begin
         sqe_cnt <= SQE_CYC[15:0];
         sqe_pulse_o <= 1'b1;
      end else if (sqe_cnt > 16'h0001) begin
         sqe_cnt <= sqe_cnt - 16'h0001;
      end else begin
         sqe_cnt <= 16'h0000;
         sqe_pulse_o <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt output
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

endmodule

`default_nettype wire

// ### dv/pcs_board.sv
// Board strap resistors and pin wiring model
`timescale 1ns/1ps
`default_nettype none
module pcs_board (
   // Strap resistor levels
   input wire logic [2:0] strap_lvl_i,
   // Device drive and enables
   input wire logic [2:0] dev_o_i,
   input wire logic [2:0] dev_oe_i,
   // Resolved pin levels
   output logic [2:0] pin_o
);
   // Device drive beats the resistor when enabled
   assign pin_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & strap_lvl_i);
endmodule
`default_nettype wire

// ### dv/pcs_top_chk.sv
// Assertion checker for the configuration pin block
`timescale 1ns/1ps
`default_nettype none
module pcs_chk (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Watched pins
   input wire hw_reset_n_i,
   input wire strap_source_select_i,
   input wire port_format_select_i,
   input wire node_or_repeater_select_i,
   input wire duplex_select_pin_i,
   input wire core_lock_i,
   input wire core_link_i,
   input wire duplex_select_pin_oe_o,
   input wire speed_select_pin_oe_o,
   input wire autoneg_select_pin_oe_o,
   input wire descrambler_lock_o,
   input wire link_up_out_o,
   input wire core_reset_o,
   input wire full_duplex_o,
   input wire repeater_o,
   input wire [1:0] port_format_o,
   input wire core_rx_active_i,
   input wire core_tx_active_i,
   input wire duplex_select_pin_o,
   input wire speed_select_pin_o,
   input wire autoneg_select_pin_o,
   input wire speed_100_o,
   input wire autoneg_en_o,
   input wire carrier_sense_o,
   input wire sqe_pulse_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Pin relations
   // ----------------------------------------
   a_lock_follow: assert property (
      !core_reset_o && !$past(core_reset_o) |-> descrambler_lock_o == $past(core_lock_i))
      else $error("lock output wrong");
   a_link_follow: assert property (
      !core_reset_o && !$past(core_reset_o) |-> link_up_out_o == $past(core_link_i))
      else $error("link output wrong");
   a_reset_hold: assert property ((!hw_reset_n_i) [*5] |-> core_reset_o)
      else $error("core not held in reset");
   a_oe_mode: assert property (
      (!core_reset_o && $stable(strap_source_select_i)) [*4]
      |-> duplex_select_pin_oe_o == strap_source_select_i) else $error("pin drive wrong");
   a_oe_agree: assert property (
      duplex_select_pin_oe_o == speed_select_pin_oe_o
      && speed_select_pin_oe_o == autoneg_select_pin_oe_o) else $error("enables differ");
   a_hw_duplex: assert property (
      (!core_reset_o && !strap_source_select_i && $stable(strap_source_select_i)
      && $stable(duplex_select_pin_i)) [*4] |-> full_duplex_o == duplex_select_pin_i)
      else $error("duplex strap ignored");
   a_role_sel: assert property (
      (!core_reset_o && $stable(node_or_repeater_select_i)) [*4]
      |-> repeater_o == node_or_repeater_select_i) else $error("role wrong");
   a_fmt_mii: assert property (
      (!core_reset_o && !port_format_select_i && $stable(port_format_select_i)) [*4]
      |-> port_format_o == 2'h0) else $error("format not mii");
   a_sw_pins: assert property (
      duplex_select_pin_oe_o |-> duplex_select_pin_o == full_duplex_o
      && speed_select_pin_o == speed_100_o && autoneg_select_pin_o == autoneg_en_o)
      else $error("driven pins differ from settings");
   a_crs_full: assert property (
      !core_reset_o && (full_duplex_o || repeater_o)
      |-> carrier_sense_o == $past(core_rx_active_i)) else $error("carrier sense on transmit");
   a_crs_half: assert property (
      !core_reset_o && !full_duplex_o && !repeater_o
      |-> carrier_sense_o == ($past(core_rx_active_i) || $past(core_tx_active_i)))
      else $error("carrier sense missing");
   a_sqe_role: assert property ($rose(sqe_pulse_o) |-> !repeater_o && !full_duplex_o)
      else $error("signal quality pulse in wrong role");
endmodule
bind pcs_top pcs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .hw_reset_n_i(hw_reset_n_i),
   .strap_source_select_i(strap_source_select_i), .port_format_select_i(port_format_select_i),
   .node_or_repeater_select_i(node_or_repeater_select_i),
   .duplex_select_pin_i(duplex_select_pin_i), .core_lock_i(core_lock_i),
   .core_link_i(core_link_i), .duplex_select_pin_oe_o(duplex_select_pin_oe_o),
   .speed_select_pin_oe_o(speed_select_pin_oe_o),
   .autoneg_select_pin_oe_o(autoneg_select_pin_oe_o), .descrambler_lock_o(descrambler_lock_o),
   .link_up_out_o(link_up_out_o), .core_reset_o(core_reset_o), .full_duplex_o(full_duplex_o),
   .repeater_o(repeater_o), .port_format_o(port_format_o),
   .core_rx_active_i(core_rx_active_i), .core_tx_active_i(core_tx_active_i),
   .duplex_select_pin_o(duplex_select_pin_o), .speed_select_pin_o(speed_select_pin_o),
   .autoneg_select_pin_o(autoneg_select_pin_o), .speed_100_o(speed_100_o),
   .autoneg_en_o(autoneg_en_o), .carrier_sense_o(carrier_sense_o), .sqe_pulse_o(sqe_pulse_o));
`default_nettype wire

// ### dv/pcs_top_tb.sv
// Self-checking testbench for the configuration pin block
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.vh"
module pcs_top_tb;
   logic clk_i, rst_i, cyc, stb, we, ack, hw_n, strap, fmt, nod, lock, link, rx, tx, txe;
   logic lock_o, link_o, creset, fd, s100, an, rep, crs, irq, sqe;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rv;
   logic [2:0] lvl, pin, po, poe;
   logic [1:0] pfmt;
   int err_total, cmp_count;
   // ----------------------------------------
   // Design and board
   // ----------------------------------------
   pcs_top #(.SQE_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .hw_reset_n_i(hw_n), .strap_source_select_i(strap),
      .port_format_select_i(fmt), .node_or_repeater_select_i(nod),
      .duplex_select_pin_i(pin[0]), .duplex_select_pin_o(po[0]),
      .duplex_select_pin_oe_o(poe[0]), .speed_select_pin_i(pin[1]),
      .speed_select_pin_o(po[1]), .speed_select_pin_oe_o(poe[1]),
      .autoneg_select_pin_i(pin[2]), .autoneg_select_pin_o(po[2]),
      .autoneg_select_pin_oe_o(poe[2]), .core_lock_i(lock), .core_link_i(link),
      .core_rx_active_i(rx), .core_tx_active_i(tx), .core_tx_end_i(txe),
      .descrambler_lock_o(lock_o), .link_up_out_o(link_o), .core_reset_o(creset),
      .full_duplex_o(fd), .speed_100_o(s100), .autoneg_en_o(an), .repeater_o(rep),
      .port_format_o(pfmt), .carrier_sense_o(crs), .sqe_pulse_o(sqe), .irq_o(irq));
   pcs_board u_board (.strap_lvl_i(lvl), .dev_o_i(po), .dev_oe_i(poe), .pin_o(pin));
   // Reference clock, 25 MHz
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic conclude;
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   // One classic cycle; read data lands in rv
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      @(posedge clk_i);
      while (ack !== 1'b1) begin
         if (n++ > 20) begin
            err_total++;
            conclude();
         end
         @(posedge clk_i);
      end
      rv = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic settle;
      repeat (6) @(posedge clk_i);
   endtask
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      conclude();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_i, hw_n, cyc, stb, we, strap, fmt, nod, lock, link, rx, tx, txe} = 13'h1800;
      {adr, sel, wdat, lvl} = '0;
      sel = 4'hF;
      err_total = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      lvl <= 3'h7;
      fmt <= 1'b1;
      nod <= 1'b1;
      settle();
      chk({poe, fd, s100, an, rep, pfmt}, {3'h0, 4'hF, 2'h1});
      lvl <= 3'h0;
      nod <= 1'b0;
      settle();
      chk({fd, s100, an, rep, pfmt}, {4'h0, 2'h2});
      fmt <= 1'b0;
      settle();
      chk(pfmt, 2'h0);
      wb(1'b1, `PCS_ADDR_IRQ_MASK, 32'h1);
      lock <= 1'b1;
      link <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk({lock_o, link_o, irq}, 3'h7);
      wb(1'b1, `PCS_ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      wb(1'b0, `PCS_ADDR_IRQ_STAT, 32'h0);
      chk(rv, 32'h1);
      wb(1'b1, `PCS_ADDR_IRQ_STAT, 32'h1);
      wb(1'b1, `PCS_ADDR_IRQ_MASK, 32'h1);
      wb(1'b0, `PCS_ADDR_IRQ_STAT, 32'h0);
      chk({rv, irq}, 33'h0);
      wb(1'b0, 8'h40, 32'h0);
      chk(rv, 32'h0);
      strap <= 1'b1;
      wb(1'b1, `PCS_ADDR_CTRL, 32'h5);
      tx <= 1'b1;
      settle();
      chk({poe, pin, fd, s100, an, crs}, {3'h7, 3'h5, 4'hA});
      wb(1'b0, `PCS_ADDR_STAT, 32'h0);
      chk(rv, 32'h18B);
      wb(1'b1, `PCS_ADDR_CTRL, 32'h0);
      settle();
      chk({pin, crs}, 4'h1);
      txe <= 1'b1;
      @(posedge clk_i);
      txe <= 1'b0;
      repeat (4) begin
         @(posedge clk_i);
         chk(sqe, 1'b1);
      end
      @(posedge clk_i);
      chk(sqe, 1'b0);
      wb(1'b1, `PCS_ADDR_CTRL, 32'h8);
      txe <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(sqe, 1'b0);
      txe <= 1'b0;
      nod <= 1'b1;
      wb(1'b1, `PCS_ADDR_CTRL, 32'h0);
      settle();
      txe <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({sqe, crs}, 2'h0);
      lock <= 1'b0;
      link <= 1'b0;
      repeat (2) @(posedge clk_i);
      wb(1'b0, `PCS_ADDR_IRQ_STAT, 32'h0);
      chk({rv, irq}, 33'hC);
      hw_n <= 1'b0;
      settle();
      chk({creset, poe, lock_o}, 5'h10);
      hw_n <= 1'b1;
      settle();
      chk(creset, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
